//--- hdl/acwmc_pkg.sv
// package: constants and types for the config word and mux control
package acwmc_pkg;
  localparam int unsigned CFG_WIDTH      = 6;
  localparam int unsigned BYTE_BITS      = 8;
  localparam int unsigned POS_INPUT_MODE = 5;
  localparam int unsigned POS_POLARITY   = 4;
  localparam int unsigned POS_RANGE      = 1;
  localparam int unsigned POS_SLEEP      = 0;
  localparam logic [5:0]  CFG_RESET      = 6'h00;
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned CONV_TYP_NS    = 1300;
  localparam int unsigned CONV_MAX_NS    = 1600;
  // longest time rounds down
  localparam int unsigned CONV_CYCLES    = (CONV_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [8:0]  CONV_LAST      = 9'(CONV_CYCLES - 1);
  localparam logic [8:0]  CNT_ZERO       = 9'h000;
  localparam logic [8:0]  CNT_ONE        = 9'h001;
  localparam logic [3:0]  BIT_ZERO       = 4'h0;
  localparam logic [3:0]  BIT_ONE        = 4'h1;
  localparam logic [3:0]  BIT_LAST       = 4'(BYTE_BITS);

  typedef struct packed {
    logic input_mode;             // 1 = single-ended
    logic polarity;               // odd/sign
    logic coding_range_select;    // 1 = unipolar
    logic deep_power_down_select; // 1 = sleep after conversion
  } acwmc_cfg_type;

  typedef struct packed {
    logic a_to_pos;
    logic a_to_neg;
    logic b_to_pos;
    logic b_to_neg;
    logic gnd_to_neg;
  } acwmc_mux_type;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV   = 2'b11,
    ST_DONE   = 2'b10
  } acwmc_state_type;
endpackage : acwmc_pkg

//--- hdl/acwmc_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module acwmc_sync (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic async_i,
  output var  logic sync_o
);
  logic meta_reg;
  logic sync_reg;
  logic meta_next;
  logic sync_next;

  always_comb begin
    meta_next = async_i;
    sync_next = meta_reg;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg;
endmodule // acwmc_sync
`default_nettype wire

//--- hdl/acwmc_top.sv
// config word capture, mux decode and conversion sequencing
// Overview of operation
// - six-bit configuration word sets mux and modes, one layout for variants
// - bits taken in order on rising scl, input mode first, sleep sixth
// - order: mode, polarity, two ignored, range, sleep; ignored bits dropped
// - fields: single/differential, polarity, unipolar/bipolar, sleep select
// - two-channel mux: 00 a+b-, 01 b+a-, 10 a vs gnd, 11 b vs gnd
// - one-channel mux: polarity alone swaps positive and negative pins
// - mux may change between conversions, using latest written word
// - one-channel variant always differential, no single-ended choice
// - positive and negative inputs sampled at one instant
// - sampling capacitor joined to selected input once per conversion
// - internal clock times conversion, at most 1.6 us
// - reset clears every configuration field to zero
// - two trailing bits of the write byte are ignored
// - result coding two's complement for bipolar, straight binary unipolar
// - after conversion enter nap or sleep per sleep select
`timescale 1ns/10ps
`default_nettype none
module acwmc_top (
  input  wire logic                    clock_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    two_channel_i,
  input  wire logic                    scl_i,
  input  wire logic                    sda_i,
  input  wire logic                    write_active_i,
  input  wire logic                    conv_start_i,
  output var  acwmc_pkg::acwmc_cfg_type cfg_o,
  output var  acwmc_pkg::acwmc_mux_type mux_o,
  output var  logic                    sample_o,
  output var  logic                    converting_o,
  output var  logic                    conv_done_o,
  output var  logic                    twos_complement_o,
  output var  logic                    nap_o,
  output var  logic                    sleep_o
);
  // ==========================================================
  // pin synchronisers
  logic scl_s;
  logic sda_s;
  logic wr_s;

  acwmc_sync u_sync_scl (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .async_i (scl_i),
    .sync_o  (scl_s)
  );
  acwmc_sync u_sync_sda (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .async_i (sda_i),
    .sync_o  (sda_s)
  );
  acwmc_sync u_sync_wr (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .async_i (write_active_i),
    .sync_o  (wr_s)
  );

  // ==========================================================
  // decode helpers
  function automatic acwmc_pkg::acwmc_cfg_type word_to_cfg(
    input logic [5:0] w
  );
    acwmc_pkg::acwmc_cfg_type c;
    c.input_mode             = w[acwmc_pkg::POS_INPUT_MODE];
    c.polarity               = w[acwmc_pkg::POS_POLARITY];
    c.coding_range_select    = w[acwmc_pkg::POS_RANGE];
    c.deep_power_down_select = w[acwmc_pkg::POS_SLEEP];
    return c;
  endfunction

  function automatic acwmc_pkg::acwmc_mux_type mux_decode(
    input acwmc_pkg::acwmc_cfg_type c,
    input logic two_ch
  );
    acwmc_pkg::acwmc_mux_type m;
    logic se;
    se = c.input_mode & two_ch;
    m  = '0;
    if (se) begin
      m.a_to_pos   = ~c.polarity;
      m.b_to_pos   = c.polarity;
      m.gnd_to_neg = 1'b1;
    end else begin
      // a/b stand for in+/in- in the one-channel part
      m.a_to_pos = ~c.polarity;
      m.b_to_neg = ~c.polarity;
      m.b_to_pos = c.polarity;
      m.a_to_neg = c.polarity;
    end
    return m;
  endfunction

  // ==========================================================
  // serial capture
  logic                      scl_d_reg;
  logic                      scl_d_next;
  logic [7:0]                shift_reg;
  logic [7:0]                shift_next;
  logic [3:0]                bits_reg;
  logic [3:0]                bits_next;
  logic [5:0]                word_reg;
  logic [5:0]                word_next;
  logic                      scl_rise;
  logic                      byte_full;
  // marker past last bit so commit happens once per byte
  localparam logic [3:0] BITS_DONE = 4'hf;

  assign scl_rise  = scl_s & ~scl_d_reg;
  assign byte_full = (bits_reg == acwmc_pkg::BIT_LAST);

  always_comb begin
    scl_d_next = scl_s;
    shift_next = shift_reg;
    bits_next  = bits_reg;
    word_next  = word_reg;
    if (!wr_s) begin
      bits_next = acwmc_pkg::BIT_ZERO;
    end else if (byte_full) begin
      // commit only when the whole byte is in; partial write discarded
      word_next = shift_reg[7:2];
      bits_next = BITS_DONE;
    end else if (scl_rise && bits_reg != BITS_DONE) begin
      shift_next = {shift_reg[6:0], sda_s};
      bits_next  = bits_reg + acwmc_pkg::BIT_ONE;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_d_reg <= 1'b0;
      shift_reg <= 8'h00;
      bits_reg  <= acwmc_pkg::BIT_ZERO;
      word_reg  <= acwmc_pkg::CFG_RESET;
    end else begin
      scl_d_reg <= scl_d_next;
      shift_reg <= shift_next;
      bits_reg  <= bits_next;
      word_reg  <= word_next;
    end
  end

  // ==========================================================
  // conversion sequencer
  acwmc_pkg::acwmc_state_type state_reg;
  acwmc_pkg::acwmc_state_type state_next;
  logic [8:0]                 cnt_reg;
  logic [8:0]                 cnt_next;
  acwmc_pkg::acwmc_cfg_type   cfg_reg;
  acwmc_pkg::acwmc_cfg_type   cfg_next;
  acwmc_pkg::acwmc_mux_type   mux_reg;
  acwmc_pkg::acwmc_mux_type   mux_next;
  logic                       sleep_reg;
  logic                       sleep_next;
  logic                       nap_reg;
  logic                       nap_next;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    cfg_next   = cfg_reg;
    mux_next   = mux_reg;
    sleep_next = sleep_reg;
    nap_next   = nap_reg;
    case (state_reg)
      acwmc_pkg::ST_IDLE: begin
        if (conv_start_i) begin
          // latest word latched per conversion, held while converting
          cfg_next   = word_to_cfg(word_reg);
          mux_next   = mux_decode(word_to_cfg(word_reg), two_channel_i);
          nap_next   = 1'b0;
          sleep_next = 1'b0;
          state_next = acwmc_pkg::ST_SAMPLE;
        end
      end
      acwmc_pkg::ST_SAMPLE: begin
        cnt_next   = acwmc_pkg::CNT_ZERO;
        state_next = acwmc_pkg::ST_CONV;
      end
      acwmc_pkg::ST_CONV: begin
        cnt_next = cnt_reg + acwmc_pkg::CNT_ONE;
        if (cnt_reg == acwmc_pkg::CONV_LAST) begin
          state_next = acwmc_pkg::ST_DONE;
        end
      end
      acwmc_pkg::ST_DONE: begin
        sleep_next = cfg_reg.deep_power_down_select;
        nap_next   = ~cfg_reg.deep_power_down_select;
        state_next = acwmc_pkg::ST_IDLE;
      end
      default: state_next = acwmc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= acwmc_pkg::ST_IDLE;
      cnt_reg   <= acwmc_pkg::CNT_ZERO;
      cfg_reg   <= '0;
      mux_reg   <= '0;
      sleep_reg <= 1'b0;
      nap_reg   <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      cfg_reg   <= cfg_next;
      mux_reg   <= mux_next;
      sleep_reg <= sleep_next;
      nap_reg   <= nap_next;
    end
  end

  // ==========================================================
  // outputs
  assign cfg_o             = cfg_reg;
  assign mux_o             = mux_reg;
  // one sample pulse: both inputs caught together
  assign sample_o          = (state_reg == acwmc_pkg::ST_SAMPLE);
  assign converting_o      = (state_reg == acwmc_pkg::ST_CONV);
  assign conv_done_o       = (state_reg == acwmc_pkg::ST_DONE);
  assign twos_complement_o = ~cfg_reg.coding_range_select;
  assign nap_o             = nap_reg;
  assign sleep_o           = sleep_reg;
endmodule // acwmc_top
`default_nettype wire

//--- testbench/acwmc_properties.sv
// checker: timing and decode relations at the top ports
`timescale 1ns/10ps
`default_nettype none
module acwmc_properties (
  input wire logic                     clock_i,
  input wire logic                     rst_n_i,
  input wire logic                     two_channel_i,
  input wire acwmc_pkg::acwmc_cfg_type cfg_o,
  input wire acwmc_pkg::acwmc_mux_type mux_o,
  input wire logic                     sample_o,
  input wire logic                     converting_o,
  input wire logic                     conv_done_o,
  input wire logic                     twos_complement_o,
  input wire logic                     nap_o,
  input wire logic                     sleep_o
);
  // ==========
  // properties
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  logic se;
  logic p;
  assign se = two_channel_i & cfg_o.input_mode;
  assign p  = cfg_o.polarity;
  // converting cycles counted: a delay that long is too costly to unroll
  logic [8:0] run_len_reg;
  logic [8:0] run_len_next;
  always_comb begin
    run_len_next = converting_o ? run_len_reg + 9'h001 : 9'h000;
  end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_len_reg <= 9'h000;
    end else begin
      run_len_reg <= run_len_next;
    end
  end
  sequence run_start_s;
    ##1 converting_o ##1 converting_o;
  endsequence
  chk_conv_start: assert property (sample_o |-> run_start_s)
    else $error("conversion did not follow sample");
  chk_conv_len: assert property (conv_done_o |->
    !converting_o && run_len_reg == acwmc_pkg::CONV_CYCLES)
    else $error("conversion length wrong");
  chk_conv_bound: assert property (converting_o |->
    run_len_reg < acwmc_pkg::CONV_CYCLES)
    else $error("conversion overran");
  chk_sample_once: assert property (sample_o |=> !sample_o [*8])
    else $error("second sample in one conversion");
  chk_done_power: assert property (conv_done_o |=>
    sleep_o == cfg_o.deep_power_down_select && nap_o != sleep_o)
    else $error("wrong power state after conversion");
  chk_start_wake: assert property (sample_o |-> !nap_o && !sleep_o)
    else $error("still asleep while sampling");
  chk_twos_range: assert property (
    twos_complement_o == !cfg_o.coding_range_select)
    else $error("result coding wrong");
  chk_mux_diff: assert property (converting_o && !se |->
    mux_o == {!p, p, p, !p, 1'b0})
    else $error("differential mux wrong");
  chk_mux_single: assert property (converting_o && se |->
    mux_o == {!p, 1'b0, p, 1'b0, 1'b1})
    else $error("single-ended mux wrong");
  chk_cfg_hold: assert property (converting_o |->
    $stable(cfg_o) && $stable(mux_o))
    else $error("config moved during conversion");
endmodule // acwmc_properties
`default_nettype wire

//--- testbench/acwmc_master.sv
// model: serial master writing configuration bytes
`timescale 1ns/10ps
`default_nettype none
module acwmc_master (
  output var logic scl_o,
  output var logic sda_o,
  output var logic wa_o
);
  // ==========
  // bus driver
  // idle scl and sda float high on the pull-ups; wa_o held low
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    wa_o  = 1'b0;
  end
  // msb first, one bit per rising scl; n below 8 aborts the byte
  task automatic send(input logic [7:0] b, input int n);
    // move onto whole nanoseconds so no pin changes on a rising clock edge
    #0.5;
    wa_o  = 1'b1;
    scl_o = 1'b0;
    #24;
    for (int i = 7; i > 7 - n; i--) begin
      sda_o = b[i];
      #24 scl_o = 1'b1;
      #24 scl_o = 1'b0;
    end
    #24 wa_o = 1'b0;
    sda_o = 1'b1;
    scl_o = 1'b1;
  endtask
endmodule // acwmc_master
`default_nettype wire

//--- testbench/tb.sv
// bench: config write, mux decode and conversion checks
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clock_i, rst_n_i, two_channel_i, conv_start_i, scl, sda, wa;
  logic sample_o, converting_o, conv_done_o, twos_complement_o;
  logic nap_o, sleep_o;
  acwmc_pkg::acwmc_cfg_type cfg_o;
  acwmc_pkg::acwmc_mux_type mux_o;
  int n_errors = 0;
  int compares = 0;
  acwmc_master m (.scl_o(scl), .sda_o(sda), .wa_o(wa));
  acwmc_top DUT (.clock_i, .rst_n_i, .two_channel_i, .scl_i(scl),
    .sda_i(sda), .write_active_i(wa), .conv_start_i, .cfg_o, .mux_o,
    .sample_o, .converting_o, .conv_done_o, .twos_complement_o,
    .nap_o, .sleep_o);
  // ==========
  // helpers
  task automatic give_verdict;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string s);
    compares++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  function automatic logic [4:0] emux(input logic [3:0] c, input logic t);
    if (t && c[3])
      return c[2] ? 5'h05 : 5'h11;
    return c[2] ? 5'h0c : 5'h12;
  endfunction
  task automatic conv(input logic [3:0] c, input logic t);
    int k;
    @(posedge clock_i) conv_start_i <= 1'b1;
    @(posedge clock_i) conv_start_i <= 1'b0;
    // look after the edge, while the one-cycle sample pulse stands
    #1;
    for (k = 0; sample_o !== 1'b1 && k < 8; k++)
      tick(1);
    chk(sample_o === 1'b1 && k == 0, "sample pulse");
    chk(cfg_o === c, "config in use");
    chk(mux_o === emux(c, t), "mux setting");
    chk(twos_complement_o === !c[1], "coding");
    for (; conv_done_o !== 1'b1 && k < 400; k++)
      tick(1);
    chk(k == acwmc_pkg::CONV_CYCLES + 1, "conversion time");
    tick(1);
    chk(sleep_o === c[0] && nap_o === !c[0], "power state");
  endtask
  // ==========
  // scenarios
  task automatic s_reset;
    @(posedge clock_i) rst_n_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    tick(4);
    chk(cfg_o === 4'h0 && mux_o === 5'h00, "reset config");
    chk(nap_o === 1'b1 && sleep_o === 1'b0, "reset power");
  endtask
  // ignored positions and first trailing bit carry varied values; last bit always 1
  task automatic s_words;
    logic [3:0] c;
    for (int i = 0; i < 32; i++) begin
      c = i[3:0];
      @(posedge clock_i) two_channel_i <= i[4];
      m.send({c[3:2], ~c[2], c[3], c[1:0], ~c[0], 1'b1}, 8);
      tick(4);
      conv(c, i[4]);
    end
  endtask
  task automatic s_partial;
    m.send(8'h00, 5);
    tick(4);
    conv(4'hf, 1'b1);
  endtask
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  initial begin
    rst_n_i = 1'b0;
    two_channel_i = 1'b1;
    conv_start_i = 1'b0;
    s_reset;
    s_words;
    s_partial;
    s_reset;
    conv(4'h0, 1'b1);
    give_verdict;
  end
  // about four times the expected run
  initial begin
    #300000;
    n_errors++;
    give_verdict;
  end
endmodule // tb
bind acwmc_top acwmc_properties chk_i (.clock_i(clock_i),
  .rst_n_i(rst_n_i), .two_channel_i(two_channel_i), .cfg_o(cfg_o),
  .mux_o(mux_o), .sample_o(sample_o), .converting_o(converting_o),
  .conv_done_o(conv_done_o), .twos_complement_o(twos_complement_o),
  .nap_o(nap_o), .sleep_o(sleep_o));
`default_nettype wire
